// ==== coll_page_consts.svh ====
// register indices, reset values, field positions and coding constants
// assumes: included by bare name from the design modules
`ifndef COLL_PAGE_CONSTS_SVH
`define COLL_PAGE_CONSTS_SVH
`define IDX_COLL 6'h0E
`define IDX_PAGE 6'h10
`define IDX_MODE 6'h11
`define IDX_IRQ_STAT 6'h20
`define IDX_IRQ_MASK 6'h21
`define IDX_LSB 2
`define IDX_MSB 7
`define RST_KEEP 1'b1
`define RST_INV 1'b1
`define RST_USE_PAGE 1'b0
`define RST_PAGE_SEL 2'h0
`define RST_MODE 8'h3B
`define RST_MASK 3'h0
`define COLL_KEEP_BIT 7
`define PAGE_USE_BIT 7
`define PAGE_SEL_MSB 1
`define MODE_MSB_FIRST 7
`define MODE_DET_SYNC 6
`define MODE_TX_WAIT 5
`define MODE_RX_WAIT 4
`define MODE_POL 3
`define MODE_DET_OFF 2
`define MODE_PRESET_MSB 1
`define IRQ_COLL 0
`define IRQ_SECURE_ELEMENT_INPUT 1
`define IRQ_CRC 2
`define COLL_MAX_POS 6'h20
`define COLL_CNT_MAX 6'h3F
`define CRC_PRESET_0 16'h0000
`define CRC_PRESET_1 16'h6363
`define CRC_PRESET_2 16'hA671
`define CRC_PRESET_3 16'hFFFF
`define CRC_POLY_N 16'h1021
`define CRC_POLY_R 16'h8408
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== coll_page_pkg.sv ====
// shared types of the collision, page and mode register block
// assumes: consts header on the include path
package coll_page_pkg;
   typedef enum logic [1:0] {
      CRC_P_ZERO = 2'h0,
      CRC_P_6363 = 2'h1,
      CRC_P_A671 = 2'h2,
      CRC_P_ALT = 2'h3
   } crc_preset_t;
   typedef logic [2:0] irq_vec_t;
   typedef struct packed {
      logic aw_have;
      logic [5:0] aw_idx;
      logic w_have;
      logic [7:0] w_byte;
      logic w_strb0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic keep;
      logic use_page;
      logic [1:0] page;
      logic [7:0] mode;
      irq_vec_t stat;
      irq_vec_t mask;
      logic [1:0] field_sync;
      logic [1:0] sig_sync;
      logic sig_act;
      logic [5:0] reg_addr;
   } regs_t;
   typedef struct packed {
      logic [5:0] cnt;
      logic seen;
      logic [4:0] pos;
      logic inv;
      logic bit_out;
      logic out_valid;
      logic first;
   } trk_t;
   typedef struct packed {
      logic [15:0] crc;
      logic [15:0] result;
      logic done;
   } crc_t;
endpackage

// ==== coll_page_if.sv ====
// carriers between the register block and its collision and crc helpers
// assumes: all signals on one clock, driven by the named modport owner
interface coll_if;
   logic start;
   logic bit_valid;
   logic bit_data;
   logic bit_coll;
   logic keep;
   logic [4:0] pos;
   logic inv;
   logic bit_out;
   logic bit_out_valid;
   logic first_coll;
   modport tracker (input start, bit_valid, bit_data, bit_coll, keep,
      output pos, inv, bit_out, bit_out_valid, first_coll);
   modport ctrl (output start, bit_valid, bit_data, bit_coll, keep,
      input pos, inv, bit_out, bit_out_valid, first_coll);
endinterface

interface crc_if;
   logic start;
   logic byte_valid;
   logic [7:0] data;
   logic msb_first;
   logic [1:0] preset;
   logic [15:0] result;
   logic done;
   modport engine (input start, byte_valid, data, msb_first, preset,
      output result, done);
   modport ctrl (output start, byte_valid, data, msb_first, preset,
      input result, done);
endinterface

// ==== collision_tracker.sv ====
// first-collision position tracker and post-collision bit clearing
// assumes: start pulses once before a frame, one data bit per bit_valid
`include "coll_page_consts.svh"
module collision_tracker
   import coll_page_pkg::*;
#(
   parameter int POS_W = 5
)
(
   input wire logic aclk,
   input wire logic aresetn,
   coll_if.tracker cif
);
   trk_t q;
   trk_t d;
   logic [5:0] cnt_n;

   if (POS_W != 5)
   begin : g_chk
      $error("collision_tracker serves a five-bit position only");
   end

   assign cnt_n = q.cnt + 6'h01;

   always_comb
   begin
      d = q;
      d.out_valid = 1'b0;
      d.first = 1'b0;
      if (cif.start)
      begin
         d.cnt = '0;
         d.seen = 1'b0;
         d.pos = '0;
         d.inv = `RST_INV;
      end
      else if (cif.bit_valid)
      begin
         if (q.cnt != `COLL_CNT_MAX)
            d.cnt = cnt_n;
         d.out_valid = 1'b1;
         d.bit_out = (q.seen && !cif.keep) ? 1'b0 : cif.bit_data;
         if (cif.bit_coll && !q.seen)
         begin
            d.seen = 1'b1;
            d.first = 1'b1;
            if (q.cnt < `COLL_MAX_POS)
            begin
               d.pos = cnt_n[4:0];
               d.inv = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         q <= '{inv: `RST_INV, default: '0};
      else
         q <= d;
   end

   assign cif.pos = q.pos;
   assign cif.inv = q.inv;
   assign cif.bit_out = q.bit_out;
   assign cif.bit_out_valid = q.out_valid;
   assign cif.first_coll = q.first;

   chk_start_refresh: assert property (@(posedge aclk) disable iff (!aresetn)
      cif.start |=> cif.inv && !q.seen)
      else $error("frame start did not refresh collision state");
   chk_clear_after: assert property (@(posedge aclk) disable iff (!aresetn)
      q.seen && !cif.keep && cif.bit_valid && !cif.start |=> cif.bit_out_valid && !cif.bit_out)
      else $error("bit after collision not cleared");
   chk_pos_first: assert property (@(posedge aclk) disable iff (!aresetn)
      cif.bit_valid && cif.bit_coll && !q.seen && !cif.start && q.cnt < `COLL_MAX_POS
      |=> cif.pos == 5'($past(cnt_n)) && !cif.inv)
      else $error("first collision position wrong");
   chk_pos_range: assert property (@(posedge aclk) disable iff (!aresetn)
      cif.bit_valid && cif.bit_coll && !q.seen && !cif.start && q.cnt >= `COLL_MAX_POS
      |=> cif.inv)
      else $error("out of range collision not flagged invalid");
   cov_collision: cover property (@(posedge aclk) disable iff (!aresetn)
      cif.first_coll && !cif.inv);
endmodule

// ==== crc_engine.sv ====
// byte-wide crc16 engine for the standalone crc command
// assumes: start loads the preset, then one byte per byte_valid pulse
`include "coll_page_consts.svh"
module crc_engine
   import coll_page_pkg::*;
#(
   parameter int DATA_W = 8
)
(
   input wire logic aclk,
   input wire logic aresetn,
   crc_if.engine crif
);
   crc_t q;
   crc_t d;
   logic [15:0] nxt;

   if (DATA_W != 8)
   begin : g_chk
      $error("crc_engine serves byte-wide data only");
   end

   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b,
      input logic msb);
      logic [15:0] r;
      logic fb;
      r = c;
      fb = 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         if (msb)
         begin
            fb = r[15] ^ b[7 - i];
            r = {r[14:0], 1'b0};
            if (fb)
               r = r ^ `CRC_POLY_N;
         end
         else
         begin
            fb = r[0] ^ b[i];
            r = {1'b0, r[15:1]};
            if (fb)
               r = r ^ `CRC_POLY_R;
         end
      end
      return r;
   endfunction

   assign nxt = crc_step(q.crc, crif.data, crif.msb_first);

   always_comb
   begin
      d = q;
      d.done = 1'b0;
      if (crif.start)
      begin
         case (crc_preset_t'(crif.preset))
            CRC_P_ZERO: d.crc = `CRC_PRESET_0;
            CRC_P_6363: d.crc = `CRC_PRESET_1;
            CRC_P_A671: d.crc = `CRC_PRESET_2;
            default: d.crc = `CRC_PRESET_3;
         endcase
      end
      else if (crif.byte_valid)
      begin
         d.crc = nxt;
         d.done = 1'b1;
         d.result = crif.msb_first ? {<<{nxt}} : nxt;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         q <= '0;
      else
         q <= d;
   end

   assign crif.result = q.result;
   assign crif.done = q.done;

   chk_preset_sel: assert property (@(posedge aclk) disable iff (!aresetn)
      crif.start && crif.preset == 2'h2 |=> q.crc == `CRC_PRESET_2)
      else $error("crc preset not loaded");
   cov_crc_msb: cover property (@(posedge aclk) disable iff (!aresetn)
      crif.done && crif.msb_first);
endmodule

// ==== collision_page_mode_regs.sv ====
// collision status, page select and general mode registers on axi4-lite
// assumes: link-side inputs on aclk except rf_field_pin and secure_element_input
`include "coll_page_consts.svh"

// Functional notes
// - keep bit low clears bits after collision
// - invalid flag when none or out of range
// - five-bit field gives first collided data bit
// - page enabled: page field forms A5 A4
// - page disabled: address from latch alone
// - page field ignored unless enable set
// - msb-first crc while mode bit 7 set and rf_active low, whole 16-bit result bit reversed
// - crc preset selects start value
// - wait-for-field gates reader transmit start
// - polarity bit sets input sense, raises event
module collision_page_mode_regs
   import coll_page_pkg::*;
#(
   parameter int AXI_ADDR_W = 8
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic rx_start,
   input wire logic rx_bit_valid,
   input wire logic rx_bit_data,
   input wire logic rx_bit_collision,
   output logic rx_bit_out,
   output logic rx_bit_out_valid,
   input wire logic [5:0] latch_addr,
   output logic [5:0] reg_addr,
   input wire logic crc_start,
   input wire logic crc_byte_valid,
   input wire logic [7:0] crc_byte,
   input wire logic rf_active,
   output logic [15:0] crc_result,
   output logic crc_done,
   input wire logic tx_request,
   input wire logic reader_mode,
   input wire logic rf_field_pin,
   output logic tx_start,
   input wire logic secure_element_input,
   output logic secure_input_active,
   output logic detect_sync,
   output logic rx_wait_for_field,
   output logic mode_detector_disable,
   output logic irq
);
   regs_t q;
   regs_t d;
   coll_if cif();
   crc_if crif();
   logic field_s;
   logic sig_s;
   logic act;
   logic pol_chg;

   if (AXI_ADDR_W < 8)
   begin : g_chk
      $error("register block needs at least eight address bits");
   end

   collision_tracker #(
      .POS_W(5)
   ) u_trk (
      .aclk(aclk),
      .aresetn(aresetn),
      .cif(cif.tracker)
   );

   crc_engine #(
      .DATA_W(8)
   ) u_crc (
      .aclk(aclk),
      .aresetn(aresetn),
      .crif(crif.engine)
   );

   assign cif.start = rx_start;
   assign cif.bit_valid = rx_bit_valid;
   assign cif.bit_data = rx_bit_data;
   assign cif.bit_coll = rx_bit_collision;
   assign cif.keep = q.keep;
   assign crif.start = crc_start;
   assign crif.byte_valid = crc_byte_valid;
   assign crif.data = crc_byte;
   assign crif.msb_first = q.mode[`MODE_MSB_FIRST] && !rf_active;
   assign crif.preset = q.mode[`MODE_PRESET_MSB:0];

   assign field_s = q.field_sync[1];
   assign sig_s = q.sig_sync[1];

   assign s_axi_awready = !q.aw_have && !q.bvalid;
   assign s_axi_wready = !q.w_have && !q.bvalid;
   assign s_axi_arready = !q.rvalid;

   always_comb
   begin
      logic [5:0] ridx;
      irq_vec_t clr;
      irq_vec_t set;
      d = q;
      ridx = s_axi_araddr[`IDX_MSB:`IDX_LSB];
      clr = '0;
      set = '0;
      pol_chg = 1'b0;
      d.field_sync = {q.field_sync[0], rf_field_pin};
      d.sig_sync = {q.sig_sync[0], secure_element_input};
      if (s_axi_awvalid && s_axi_awready)
      begin
         d.aw_have = 1'b1;
         d.aw_idx = s_axi_awaddr[`IDX_MSB:`IDX_LSB];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         d.w_have = 1'b1;
         d.w_byte = s_axi_wdata[7:0];
         d.w_strb0 = s_axi_wstrb[0];
      end
      if (q.bvalid && s_axi_bready)
         d.bvalid = 1'b0;
      if (q.aw_have && q.w_have)
      begin
         d.aw_have = 1'b0;
         d.w_have = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = `RESP_OKAY;
         if (q.aw_idx == `IDX_COLL)
         begin
            if (q.w_strb0)
               d.keep = q.w_byte[`COLL_KEEP_BIT];
         end
         else if (q.aw_idx == `IDX_PAGE)
         begin
            if (q.w_strb0)
            begin
               d.use_page = q.w_byte[`PAGE_USE_BIT];
               d.page = q.w_byte[`PAGE_SEL_MSB:0];
            end
         end
         else if (q.aw_idx == `IDX_MODE)
         begin
            if (q.w_strb0)
            begin
               d.mode = q.w_byte;
               pol_chg = q.w_byte[`MODE_POL] != q.mode[`MODE_POL];
            end
         end
         else if (q.aw_idx == `IDX_IRQ_STAT)
         begin
            d.bresp = `RESP_OKAY;
         end
         else if (q.aw_idx == `IDX_IRQ_MASK)
         begin
            if (q.w_strb0)
               d.mask = q.w_byte[2:0];
         end
         else
         begin
            d.bresp = `RESP_SLVERR;
         end
      end
      if (q.rvalid && s_axi_rready)
         d.rvalid = 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
         d.rvalid = 1'b1;
         d.rresp = `RESP_OKAY;
         d.rdata = '0;
         if (ridx == `IDX_COLL)
         begin
            d.rdata[7:0] = {q.keep, 1'b0, cif.inv, cif.pos};
         end
         else if (ridx == `IDX_PAGE)
         begin
            d.rdata[7:0] = {q.use_page, 5'h00, q.page};
         end
         else if (ridx == `IDX_MODE)
         begin
            d.rdata[7:0] = q.mode;
         end
         else if (ridx == `IDX_IRQ_STAT)
         begin
            d.rdata[2:0] = q.stat;
            clr = q.stat;
         end
         else if (ridx == `IDX_IRQ_MASK)
         begin
            d.rdata[2:0] = q.mask;
         end
         else
         begin
            d.rresp = `RESP_SLVERR;
         end
      end
      act = q.mode[`MODE_POL] ? sig_s : !sig_s;
      d.sig_act = act;
      set[`IRQ_SECURE_ELEMENT_INPUT] = pol_chg || (act && !q.sig_act);
      set[`IRQ_COLL] = cif.first_coll;
      set[`IRQ_CRC] = crif.done;
      // set wins over read clear
      d.stat = (q.stat & ~clr) | set;
      if (q.use_page)
         d.reg_addr = {q.page, latch_addr[3:0]};
      else
         d.reg_addr = latch_addr;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         q <= '{keep: `RST_KEEP, use_page: `RST_USE_PAGE, page: `RST_PAGE_SEL,
            mode: `RST_MODE, mask: `RST_MASK, default: '0};
      else
         q <= d;
   end

   assign tx_start = tx_request && (!q.mode[`MODE_TX_WAIT] || !reader_mode || field_s);

   assign s_axi_bresp = q.bresp;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;
   assign s_axi_rvalid = q.rvalid;
   assign rx_bit_out = cif.bit_out;
   assign rx_bit_out_valid = cif.bit_out_valid;
   assign reg_addr = q.reg_addr;
   assign crc_result = crif.result;
   assign crc_done = crif.done;
   assign secure_input_active = q.sig_act;
   assign detect_sync = q.mode[`MODE_DET_SYNC];
   assign rx_wait_for_field = q.mode[`MODE_RX_WAIT];
   assign mode_detector_disable = q.mode[`MODE_DET_OFF];
   assign irq = |(q.stat & q.mask);

   chk_page_addr: assert property (@(posedge aclk) disable iff (!aresetn)
      q.use_page |=> reg_addr == {$past(q.page), $past(latch_addr[3:0])})
      else $error("paged register address wrong");
   chk_flat_addr: assert property (@(posedge aclk) disable iff (!aresetn)
      !q.use_page |=> reg_addr == $past(latch_addr))
      else $error("flat register address wrong");
   chk_page_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
      !q.use_page && q.page != latch_addr[5:4] |=> reg_addr[5:4] != $past(q.page))
      else $error("page field used while disabled");
   chk_tx_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      tx_start && reader_mode && q.mode[`MODE_TX_WAIT] |-> field_s)
      else $error("transmit started without field");
   chk_pol_event: assert property (@(posedge aclk) disable iff (!aresetn)
      $changed(q.mode[`MODE_POL]) |-> q.stat[`IRQ_SECURE_ELEMENT_INPUT])
      else $error("polarity change raised no event");
   chk_coll_irq: assert property (@(posedge aclk) disable iff (!aresetn)
      cif.first_coll && q.mask[`IRQ_COLL] |=> irq)
      else $error("collision event lost");
   chk_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered next cycle");
   chk_keep_out: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && s_axi_araddr[`IDX_MSB:`IDX_LSB] == `IDX_COLL
      |=> s_axi_rdata[`COLL_KEEP_BIT] == $past(q.keep))
      else $error("keep bit readback wrong");
   cov_page_use: cover property (@(posedge aclk) disable iff (!aresetn)
      q.use_page && q.page == 2'h3);
   cov_pol_change: cover property (@(posedge aclk) disable iff (!aresetn)
      pol_chg);
   cov_irq: cover property (@(posedge aclk) disable iff (!aresetn)
      irq ##1 !irq);
endmodule

// ==== axil_host.sv ====
// axi4-lite host model: one write and one read under way at most
// assumes: single aclk, slave answers with level valid held until ready
module axil_host
(
   input wire logic aclk,
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'h1;
   end
   // released payloads are inverted so stale values never pass
   task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] r,
      input logic [3:0] st = 4'h1);
      logic ta;
      logic tw;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {24'h0, v};
      s_axi_wstrb <= st;
      s_axi_wvalid <= 1'b1;
      ta = 1'b0;
      tw = 1'b0;
      while (!(ta && tw))
      begin
         @(negedge aclk);
         ta = ta || s_axi_awready;
         tw = tw || s_axi_wready;
         @(posedge aclk);
         s_axi_awvalid <= !ta;
         s_axi_awaddr <= ta ? ~a : a;
         s_axi_wvalid <= !tw;
         s_axi_wdata <= tw ? ~{24'h0, v} : {24'h0, v};
      end
      s_axi_bready <= 1'b1;
      do
         @(negedge aclk);
      while (!s_axi_bvalid);
      r = s_axi_bresp;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do
         @(negedge aclk);
      while (!s_axi_arready);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      s_axi_araddr <= ~a;
      s_axi_rready <= 1'b1;
      do
         @(negedge aclk);
      while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask
   task automatic set_keep(input logic anticoll, output logic [1:0] r);
      wr(8'h38, {!anticoll, 7'h0}, r);
   endtask
   function automatic logic pos_usable(input logic [7:0] c);
      return !c[5];
   endfunction
endmodule

// ==== collision_page_mode_regs_test.sv ====
// self-checking bench of the collision, page and mode register block
// assumes: design files and axil_host compiled first, one 200 MHz clock
module collision_page_mode_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr, crc_byte, v, b;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic rx_start, rx_bit_valid, rx_bit_data, rx_bit_collision, rx_bit_out, rx_bit_out_valid;
   logic [5:0] latch_addr, reg_addr, la;
   logic crc_start, crc_byte_valid, rf_active, crc_done, tx_request, reader_mode, rf_field_pin;
   logic [15:0] crc_result, c;
   logic tx_start, secure_element_input, secure_input_active, detect_sync, rx_wait_for_field;
   logic mode_detector_disable, irq, bd, keep;
   int mismatches, n_compared, cp;
   integer seed = 32'h9B0DD39E;
   collision_page_mode_regs i_dut (.*);
   axil_host i_host (.*);
   initial
   begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   task automatic check(input string n, input logic [33:0] e, input logic [33:0] g);
      n_compared++;
      if (e !== g)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge aclk);
      @(negedge aclk);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
      i_host.rd(a, d, r);
      check(n, {e, 2'h0}, {d, r});
   endtask
   function automatic logic [15:0] crc_step(logic [15:0] x, logic [7:0] y, logic m);
      x = m ? x ^ {y, 8'h00} : x ^ {8'h00, y};
      for (int k = 0; k < 8; k++)
         x = m ? (x[15] ? {x[14:0], 1'b0} ^ 16'h1021 : {x[14:0], 1'b0})
               : (x[0] ? {1'b0, x[15:1]} ^ 16'h8408 : {1'b0, x[15:1]});
      return x;
   endfunction
   function automatic logic [15:0] rev16(logic [15:0] x);
      for (int k = 0; k < 16; k++)
         rev16[k] = x[15 - k];
   endfunction
   function automatic logic [15:0] preset(logic [1:0] p);
      return p == 2'h0 ? 16'h0000 : p == 2'h1 ? 16'h6363 : p == 2'h2 ? 16'hA671 : 16'hFFFF;
   endfunction
   // watchdog: the whole run needs well under 10000 cycles
   initial
   begin
      #200000;
      mismatches++;
      print_verdict();
   end
   initial
   begin
      aresetn = 1'b0;
      {rx_start, rx_bit_valid, rx_bit_data, rx_bit_collision, crc_start, crc_byte_valid} = '0;
      {rf_active, tx_request, reader_mode, rf_field_pin, secure_element_input} = '0;
      {latch_addr, crc_byte} = '0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      rdc(8'h38, 32'hA0, "coll");
      rdc(8'h40, 32'h00, "page");
      i_host.wr(8'h44, 8'h00, r, 4'h0);
      check("nostrb_wr", 2'h0, r);
      rdc(8'h44, 32'h3B, "mode");
      check("mode_outs", 3'b010, {detect_sync, rx_wait_for_field, mode_detector_disable});
      i_host.rd(8'h3C, d, r);
      check("unmapped_rd", {32'h0, 2'h2}, {d, r});
      i_host.wr(8'hFC, 8'h00, r);
      check("unmapped_wr", 2'h2, r);
      $display("test reset done");
      for (int i = 0; i < 6; i++)
      begin
         v = i == 0 ? 8'hFF : i == 1 ? 8'h7F : 8'($random(seed));
         la = 6'($random(seed));
         i_host.wr(8'h40, v, r);
         latch_addr <= la;
         check("page_bresp", 2'h0, r);
         settle(2);
         check("reg_addr", v[7] ? {v[1:0], la[3:0]} : la, reg_addr);
         rdc(8'h40, v & 8'h83, "page");
      end
      repeat (3)
      begin
         v = 8'($random(seed)) | 8'h08;
         i_host.wr(8'h44, v, r);
         settle(1);
         check("mode_outs", {v[6], v[4], v[2]},
            {detect_sync, rx_wait_for_field, mode_detector_disable});
         rdc(8'h44, v, "mode");
      end
      $display("test page and mode done");
      for (int i = 0; i < 8; i++)
      begin
         i_host.wr(8'h44, {2'b00, i[2], 5'b11011}, r);
         reader_mode <= i[1];
         rf_field_pin <= i[0];
         tx_request <= 1'b1;
         settle(4);
         check("tx_start", !i[2] || !i[1] || i[0], tx_start);
      end
      $display("test tx gate done");
      @(posedge aclk);
      secure_element_input <= 1'b1;
      settle(4);
      check("sig_act", 1'b1, secure_input_active);
      i_host.rd(8'h80, d, r);
      i_host.wr(8'h84, 8'h02, r);
      check("irq", 1'b0, irq);
      i_host.wr(8'h44, 8'h33, r);
      settle(4);
      check("sig_act", 1'b0, secure_input_active);
      check("irq", 1'b1, irq);
      rdc(8'h80, 32'h2, "irq_stat");
      settle(1);
      check("irq", 1'b0, irq);
      @(posedge aclk);
      secure_element_input <= 1'b0;
      settle(4);
      check("sig_act", 1'b1, secure_input_active);
      rdc(8'h80, 32'h2, "irq_stat");
      $display("test polarity done");
      for (int i = 0; i < 8; i++)
      begin
         i_host.wr(8'h44, {i[2], 5'b01110, i[1:0]}, r);
         @(posedge aclk);
         rf_active <= 1'($random(seed));
         crc_start <= 1'b1;
         c = preset(i[1:0]);
         repeat (2)
         begin
            @(posedge aclk);
            crc_start <= 1'b0;
            b = 8'($random(seed));
            crc_byte <= b;
            crc_byte_valid <= 1'b1;
            @(posedge aclk);
            crc_byte_valid <= 1'b0;
            @(negedge aclk);
            c = crc_step(c, b, i[2] && !rf_active);
            check("crc_done", 1'b1, crc_done);
            check("crc", (i[2] && !rf_active) ? rev16(c) : c, crc_result);
         end
      end
      $display("test crc done");
      i_host.rd(8'h80, d, r);
      for (int f = 0; f < 6; f++)
      begin
         cp = f == 0 ? 1 : f < 3 ? 31 + f : 1 + ($unsigned($random(seed)) % 40);
         keep = f[0];
         i_host.set_keep(!keep, r);
         i_host.wr(8'h84, {7'h0, f > 0}, r);
         @(posedge aclk);
         rx_start <= 1'b1;
         @(posedge aclk);
         rx_start <= 1'b0;
         for (int n = 1; n <= 40; n++)
         begin
            bd = 1'($random(seed));
            rx_bit_data <= bd;
            rx_bit_collision <= (n == cp) || (n == cp + 3);
            rx_bit_valid <= 1'b1;
            @(posedge aclk);
            rx_bit_valid <= 1'b0;
            @(negedge aclk);
            check("bit_out", {1'b1, bd & (keep || n <= cp)},
               {rx_bit_out_valid, rx_bit_out});
            @(posedge aclk);
         end
         i_host.rd(8'h38, d, r);
         check("coll_flags", {keep, 1'b0, cp > 32}, d[7:5]);
         if (i_host.pos_usable(d[7:0]))
            check("coll_pos", cp[4:0], d[4:0]);
         if (cp <= 32)
         begin
            check("irq", f > 0, irq);
            rdc(8'h80, 32'h1, "irq_stat");
         end
         else
            i_host.rd(8'h80, d, r);
         settle(1);
         check("irq", 1'b0, irq);
      end
      $display("test collision done");
      print_verdict();
   end
endmodule
